// File: sdc_pkg.sv
// Shared types and constants for the DRAM command decode and termination block.
// Assumes a single 200 MHz system clock and ports already synchronous to it.
package sdc_pkg;

  localparam int CLK_PERIOD_PS = 5000;
  localparam int NUM_BANKS     = 4;
  localparam int ROW_W         = 12;
  localparam int COL_W         = 9;
  localparam int DATA_W        = 32;
  localparam int BYTES         = DATA_W / 8;

  // Address bit that requests auto precharge and all-bank precharge
  localparam int AUTO_PRECHARGE_ADDR_BIT = 8;

  // Bank timing in picoseconds; plain defaults, not given as figures
  localparam int ROW_ACTIVATE_TIME_PS = 10000;
  localparam int ROW_ACTIVE_TIME_PS   = 30000;
  localparam int ROW_PRECHARGE_TIME_PS = 12000;
  localparam logic [3:0] RCD_CYC =
    4'((ROW_ACTIVATE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [3:0] RAS_CYC =
    4'((ROW_ACTIVE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [3:0] RP_CYC =
    4'((ROW_PRECHARGE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // Extra clocks of data termination off beyond half the burst
  localparam logic [5:0] TERM_OFF_EXTRA = 6'h02;

  // Mode register targets on bank selects
  localparam logic [1:0] MODE_SEL_BASE = 2'h0;
  localparam logic [1:0] MODE_SEL_EXT  = 2'h1;

  typedef enum logic [2:0] {
    CMD_NOP   = 3'b000,
    CMD_ACT   = 3'b001,
    CMD_READ  = 3'b010,
    CMD_WRITE = 3'b011,
    CMD_PRE   = 3'b100,
    CMD_REF   = 3'b101,
    CMD_MODE  = 3'b110
  } sdc_cmd_e;

  typedef enum logic [1:0] {
    BANK_IDLE        = 2'b00,
    BANK_ACTIVATING  = 2'b01,
    BANK_ACTIVE      = 2'b10,
    BANK_PRECHARGING = 2'b11
  } sdc_bank_e;

  typedef struct packed {
    logic             cs_n;
    logic             ras_n;
    logic             cas_n;
    logic             we_n;
    logic             cke;
    logic             bank_select_bit1;
    logic             bank_select_bit0;
    logic [ROW_W-1:0] addr;
  } sdc_cmd_s;

  typedef struct packed {
    logic             en;
    logic [1:0]       bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [DATA_W-1:0] data;
    logic [BYTES-1:0] byte_en;
  } sdc_wr_s;

  typedef struct packed {
    logic             en;
    logic [1:0]       bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [4:0]       len;
  } sdc_rd_s;

endpackage

// File: sdc_core.sv
// Command decode, bank tracking, self refresh and read-snoop termination.
// Assumes the controller keeps its own timing rules; no array inside.
`timescale 1ns/1ps

// Notes on behaviour
// R1: Chip select high ignores new commands; running work continues.
// R2: No-operation registers nothing and leaves running work alone.
// R3: Controller loads mode only with banks idle, then waits mode delay.
// R4: Mode load bank selects 00 base, 01 extended, others reserved.
// R5: Activate opens the addressed row in the selected bank until precharge.
// R6: Controller precharges before opening another row in the same bank.
// R7: Read starts burst from open row with column and auto precharge bit.
// R8: Auto precharge closes the row at burst end, else row stays open.
// R9: Write starts burst to open row and stores data from data lines.
// R10: Mask low stores byte; mask high leaves that byte unchanged.
// R11: Precharge closes all banks with auto precharge bit high, else one.
// R12: Controller waits precharge time and activates before any access.
// R13: Auto precharge per access, earliest point meeting minimum row active.
// R14: Controller issues nothing to that bank until precharge time elapses.
// R15: Refresh rows come from internal counter; refresh every 3.9us.
// R16: Controller never spaces refreshes beyond nine average intervals.
// R17: Refresh with clock enable low enters self refresh, ignoring inputs.
// R18: Self refresh disables loop and termination; exit re-enables, resets loop.
// R19: Controller stabilises clock, sends no-ops, waits 20K cycles before read.
// R20: Dual load read snoop turns data term off latency-1 for half burst+2.
// R21: Command and address termination stays enabled in every configuration.
// R22: Clock enable at reset release picks single or dual rank.
// R23: Select, row, column and write strobes decode the command set.
// R24: Refresh code is auto refresh with enable high, self refresh low.
// R25: Track bank states; accesses to banks without open row are ignored.
module sdc_core
  import sdc_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire sdc_cmd_s           cmd,
  input  wire logic [DATA_W-1:0]  wdata,
  input  wire logic [BYTES-1:0]   write_byte_mask,
  input  wire logic [3:0]         read_latency,
  input  wire logic [4:0]         burst_length,
  input  wire logic               dual_load_term,
  output sdc_wr_s                 arr_wr,
  output sdc_rd_s                 arr_rd,
  output logic [ROW_W-1:0]        mode_reg,
  output logic [ROW_W-1:0]        ext_mode_reg,
  output logic                    refresh_pulse,
  output logic [ROW_W-1:0]        refresh_row,
  output logic                    self_refresh,
  output logic                    dll_enable,
  output logic                    dll_reset,
  output logic                    dq_term_enable,
  output logic                    cmd_term_enable,
  output logic                    dual_rank,
  output logic                    addr_term_half,
  output logic [NUM_BANKS-1:0]    bank_open
);

  function automatic sdc_cmd_e decode(input sdc_cmd_s c);
    // R23: strobe decoding
    if (c.cs_n)
      return CMD_NOP;
    unique case ({c.ras_n, c.cas_n, c.we_n})
      3'b011:  return CMD_ACT;
      3'b101:  return CMD_READ;
      3'b100:  return CMD_WRITE;
      3'b010:  return CMD_PRE;
      3'b001:  return CMD_REF;
      3'b000:  return CMD_MODE;
      default: return CMD_NOP;
    endcase
  endfunction
  sdc_cmd_e         op;
  logic [1:0]       sel_bank;
  logic             ap_bit;
  logic [COL_W-1:0] col_addr;
  sdc_bank_e        bstate [NUM_BANKS];
  logic [ROW_W-1:0] brow [NUM_BANKS];
  logic             rst_q;
  logic [5:0]       snoop_age;
  logic [5:0]       next_snoop_age;
  logic [5:0]       off_end;
  logic [4:0]       wr_left;
  // R1: commands ignored when deselected or in self refresh
  // R2: no-operation decodes to nothing
  assign op       = self_refresh ? CMD_NOP : decode(cmd);
  assign sel_bank = {cmd.bank_select_bit1, cmd.bank_select_bit0};
  assign ap_bit   = cmd.addr[AUTO_PRECHARGE_ADDR_BIT];
  // R7: column from A0-A7 and A9
  assign col_addr = {cmd.addr[9], cmd.addr[7:0]};
  generate
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      logic [3:0] tmr;
      logic [3:0] ras_left;
      logic [4:0] burst_left;
      logic       ap_pend;
      logic       hit;
      logic       pre_hit;
      logic       access;
      logic       ap_fire;
      assign hit     = (sel_bank == 2'(b));
      // R11: all banks with the precharge bit high, else the selected one
      assign pre_hit = (op == CMD_PRE) && (ap_bit || hit);
      // R25: accesses only to an open row
      assign access  = (op == CMD_READ || op == CMD_WRITE) && hit &&
                       (bstate[b] == BANK_ACTIVE);
      // R13: earliest point that meets minimum row active time
      assign ap_fire = ap_pend && (burst_left == 5'h00) &&
                       (ras_left == 4'h0) && (bstate[b] == BANK_ACTIVE);

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          bstate[b] <= BANK_IDLE;
          brow[b]   <= '0;
          tmr       <= 4'h0;
        end else begin
          unique case (bstate[b])
            BANK_IDLE: begin
              // R5: open the addressed row
              if (op == CMD_ACT && hit) begin
                bstate[b] <= BANK_ACTIVATING;
                brow[b]   <= cmd.addr;
                tmr       <= RCD_CYC - 4'h1;
              end
            end
            BANK_ACTIVATING, BANK_ACTIVE: begin
              // R8: auto precharge or explicit precharge closes the row
              if (pre_hit || ap_fire) begin
                bstate[b] <= BANK_PRECHARGING;
                tmr       <= RP_CYC - 4'h1;
              end else if (bstate[b] == BANK_ACTIVATING) begin
                if (tmr == 4'h0)
                  bstate[b] <= BANK_ACTIVE;
                else
                  tmr <= tmr - 4'h1;
              end
            end
            BANK_PRECHARGING: begin
              if (tmr == 4'h0)
                bstate[b] <= BANK_IDLE;
              else
                tmr <= tmr - 4'h1;
            end
          endcase
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          ras_left   <= 4'h0;
          burst_left <= 5'h00;
          ap_pend    <= 1'b0;
        end else begin
          if (op == CMD_ACT && hit && bstate[b] == BANK_IDLE)
            ras_left <= RAS_CYC - 4'h1;
          else if (ras_left != 4'h0)
            ras_left <= ras_left - 4'h1;
          // R13: auto precharge belongs to this access only
          if (access) begin
            burst_left <= burst_length;
            ap_pend    <= ap_bit;
          end else begin
            if (burst_left != 5'h00)
              burst_left <= burst_left - 5'h01;
            if (ap_fire || pre_hit)
              ap_pend <= 1'b0;
          end
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst)
          bank_open[b] <= 1'b0;
        else
          bank_open[b] <= (bstate[b] == BANK_ACTIVE);
      end
      // R25: a read to a closed bank starts no burst
      closed_access_a: assert property (@(posedge clk_sys) disable iff (rst)
        (op == CMD_READ && hit && bstate[b] != BANK_ACTIVE && !arr_rd.en)
        |=> !arr_rd.en)
        else $error("read on closed bank started a burst");
      // R11: all-bank precharge closes this bank
      pre_close_a: assert property (@(posedge clk_sys) disable iff (rst)
        (op == CMD_PRE && ap_bit && bstate[b] inside
          {BANK_ACTIVATING, BANK_ACTIVE})
        |=> bstate[b] == BANK_PRECHARGING)
        else $error("precharge all missed a bank");
    end
  endgenerate
  // R7: read burst request from the open row
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      arr_rd <= '0;
    end else begin
      arr_rd.en <= (op == CMD_READ) && (bstate[sel_bank] == BANK_ACTIVE);
      arr_rd.bank <= sel_bank;
      arr_rd.row  <= brow[sel_bank];
      arr_rd.col  <= col_addr;
      arr_rd.len  <= burst_length;
    end
  end
  // R9: write beats follow the command one per clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_left <= 5'h00;
      arr_wr  <= '0;
    end else if (op == CMD_WRITE && bstate[sel_bank] == BANK_ACTIVE) begin
      wr_left      <= burst_length;
      arr_wr.en    <= 1'b0;
      arr_wr.bank  <= sel_bank;
      arr_wr.row   <= brow[sel_bank];
      arr_wr.col   <= col_addr - COL_W'(1);
    end else if (wr_left != 5'h00) begin
      wr_left        <= wr_left - 5'h01;
      arr_wr.en      <= 1'b1;
      arr_wr.col     <= arr_wr.col + COL_W'(1);
      arr_wr.data    <= wdata;
      // R10: mask high blocks the byte
      arr_wr.byte_en <= ~write_byte_mask;
    end else begin
      arr_wr.en <= 1'b0;
    end
  end
  // R4: bank selects choose the mode register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_reg     <= '0;
      ext_mode_reg <= '0;
    end else if (op == CMD_MODE) begin
      if (sel_bank == MODE_SEL_BASE)
        mode_reg <= cmd.addr;
      else if (sel_bank == MODE_SEL_EXT)
        ext_mode_reg <= cmd.addr;
    end
  end
  // R15: internal counter supplies refresh rows
  // R24: auto refresh only with clock enable high
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      refresh_pulse <= 1'b0;
      refresh_row   <= '0;
    end else begin
      refresh_pulse <= (op == CMD_REF) && cmd.cke;
      if (op == CMD_REF && cmd.cke)
        refresh_row <= refresh_row + ROW_W'(1);
    end
  end
  // R17: self refresh entry and exit on clock enable
  // R18: loop and termination follow self refresh
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      self_refresh <= 1'b0;
      dll_enable   <= 1'b1;
      dll_reset    <= 1'b0;
    end else begin
      dll_reset <= 1'b0;
      if (!self_refresh && op == CMD_REF && !cmd.cke) begin
        self_refresh <= 1'b1;
        dll_enable   <= 1'b0;
      end else if (self_refresh && cmd.cke) begin
        self_refresh <= 1'b0;
        dll_enable   <= 1'b1;
        dll_reset    <= 1'b1;
      end
    end
  end
  // R20: read snoop ignores chip select
  assign off_end = {2'h0, read_latency} + {2'h0, burst_length[4:1]} +
                   TERM_OFF_EXTRA - 6'h01;
  always_comb begin
    next_snoop_age = snoop_age;
    if (cmd.ras_n && !cmd.cas_n && cmd.we_n && !self_refresh)
      next_snoop_age = 6'h01;
    else if (snoop_age != 6'h00 && snoop_age != 6'h3f)
      next_snoop_age = snoop_age + 6'h01;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      snoop_age      <= 6'h00;
      dq_term_enable <= 1'b1;
    end else begin
      snoop_age <= next_snoop_age;
      // R20: off latency-1 clocks after the read for half burst + 2
      // R18: off while in self refresh
      dq_term_enable <= !(self_refresh || (!cmd.cke && op == CMD_REF)) &&
        !(dual_load_term && next_snoop_age != 6'h00 &&
          next_snoop_age >= {2'h0, read_latency} - 6'h01 &&
          next_snoop_age < off_end);
    end
  end
  // R22: rank from clock enable at reset release
  // R21: command and address termination always on
  always_ff @(posedge clk_sys) begin
    rst_q <= rst;
    if (rst) begin
      cmd_term_enable <= 1'b1;
      dual_rank       <= 1'b0;
      addr_term_half  <= 1'b0;
    end else if (rst_q) begin
      dual_rank      <= cmd.cke;
      addr_term_half <= !cmd.cke;
    end
  end
  read_start_a: assert property (@(posedge clk_sys) disable iff (rst) // R7
    arr_rd.en |-> $past(op) == CMD_READ && arr_rd.col == $past(col_addr))
    else $error("read burst without a read command");
  deselect_quiet_a: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (cmd.cs_n && !arr_wr.en && wr_left == 5'h00) |=> !arr_rd.en)
    else $error("deselected cycle started a burst");
  mask_store_a: assert property (@(posedge clk_sys) disable iff (rst) // R10
    (wr_left != 5'h00 && op != CMD_WRITE)
    |=> arr_wr.en && arr_wr.byte_en == ~$past(write_byte_mask))
    else $error("byte enable does not follow mask");
  sr_loop_a: assert property (@(posedge clk_sys) disable iff (rst) // R18
    (self_refresh && cmd.cke) |=> dll_enable && dll_reset ##1 !dll_reset)
    else $error("loop not re-enabled on exit");
  sr_term_a: assert property (@(posedge clk_sys) disable iff (rst) // R18
    self_refresh |-> !dll_enable && !dq_term_enable)
    else $error("loop or termination on in self refresh");
  term_window_a: assert property (@(posedge clk_sys) disable iff (rst) // R20
    (dual_load_term && cmd.ras_n && !cmd.cas_n && cmd.we_n &&
     !self_refresh && read_latency == 4'h5 && burst_length == 5'h04)
    ##1 (dual_load_term && cmd.cas_n && !self_refresh && cmd.cke) [*8]
    |-> $past(dq_term_enable, 5) && !$past(dq_term_enable, 4) &&
        !$past(dq_term_enable, 1) && dq_term_enable)
    else $error("termination off window wrong");
  cmd_term_a: assert property (@(posedge clk_sys) disable iff (rst) // R21
    cmd_term_enable)
    else $error("command termination dropped");
  refresh_row_a: assert property (@(posedge clk_sys) disable iff (rst) // R15
    refresh_pulse |-> refresh_row == $past(refresh_row) + ROW_W'(1))
    else $error("refresh row did not advance");
  cover property (@(posedge clk_sys) disable iff (rst) arr_rd.en);
  cover property (@(posedge clk_sys) disable iff (rst) arr_wr.en);
  cover property (@(posedge clk_sys) disable iff (rst)
    self_refresh ##1 !self_refresh);
  cover property (@(posedge clk_sys) disable iff (rst) !dq_term_enable);
endmodule

// File: sdc_ctl_model.sv
// Memory controller model: drives command bus, write data and masks.
// Assumes the caller spaces commands as the bank timing requires.
`timescale 1ns/1ps
module sdc_ctl_model
  import sdc_pkg::*;
(
  input  wire logic         clk_sys,
  output sdc_cmd_s          cmd,
  output logic [DATA_W-1:0] wdata,
  output logic [BYTES-1:0]  write_byte_mask
);
  initial begin
    cmd             = {4'hf, 1'b1, 2'h0, 12'h000};
    wdata           = 32'h0000_0000;
    write_byte_mask = 4'hf;
  end

  // One command for one edge, then deselect with the address inverted
  task automatic send(input logic [3:0] code, input logic ck,
                      input logic [1:0] ba, input logic [11:0] a);
    @(posedge clk_sys);
    cmd <= {code, ck, ba, a};
    @(posedge clk_sys);
    cmd <= {4'hf, ck, ba, ~a};
  endtask

  task automatic gap(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic write(input logic [1:0] ba, input logic [11:0] a,
                       input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    cmd <= {4'h4, 1'b1, ba, a};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      // no-op and deselect alternate in the burst
      cmd             <= {i[0], 3'h7, 1'b1, ba, ~a};
      wdata           <= d + DATA_W'(i);
      write_byte_mask <= BYTES'(i * 5);
    end
    @(posedge clk_sys);
    cmd             <= {4'hf, 1'b1, ba, ~a};
    wdata           <= ~d;
    write_byte_mask <= 4'ha;
  endtask
endmodule

// File: testbench.sv
// Self-checking bench for the command decode and termination block.
// Assumes a 200 MHz clock; run is far shorter than one refresh interval.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("unexpected %s expected %h seen %h", nm, exp, got); \
    end \
  end
module testbench
  import sdc_pkg::*;
  ;
  logic                 clk_sys        = 1'b0;
  logic                 rst            = 1'b1;
  logic [3:0]           read_latency   = 4'h4;
  logic [4:0]           burst_length   = 5'h04;
  logic                 dual_load_term = 1'b0;
  sdc_cmd_s             cmd;
  logic [DATA_W-1:0]    wdata;
  logic [BYTES-1:0]     write_byte_mask;
  sdc_wr_s              arr_wr;
  sdc_rd_s              arr_rd;
  logic [ROW_W-1:0]     mode_reg, ext_mode_reg, refresh_row, r0;
  logic                 refresh_pulse, self_refresh, dll_enable;
  logic                 dll_reset, dq_term_enable, cmd_term_enable;
  logic                 dual_rank, addr_term_half;
  logic [NUM_BANKS-1:0] bank_open;
  int                   fails        = 0;
  int                   total_checks = 0;
  int                   cycles       = 0;
  sdc_wr_s              wq[$];
  sdc_rd_s              rq[$];

  sdc_ctl_model ctl (.clk_sys(clk_sys), .cmd(cmd), .wdata(wdata),
    .write_byte_mask(write_byte_mask));
  sdc_core dut (.clk_sys(clk_sys), .rst(rst), .cmd(cmd), .wdata(wdata),
    .write_byte_mask(write_byte_mask), .read_latency(read_latency),
    .burst_length(burst_length), .dual_load_term(dual_load_term),
    .arr_wr(arr_wr), .arr_rd(arr_rd), .mode_reg(mode_reg),
    .ext_mode_reg(ext_mode_reg), .refresh_pulse(refresh_pulse),
    .refresh_row(refresh_row), .self_refresh(self_refresh),
    .dll_enable(dll_enable), .dll_reset(dll_reset),
    .dq_term_enable(dq_term_enable), .cmd_term_enable(cmd_term_enable),
    .dual_rank(dual_rank), .addr_term_half(addr_term_half),
    .bank_open(bank_open));

  always #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (arr_wr.en === 1'b1) wq.push_back(arr_wr);
    if (arr_rd.en === 1'b1) rq.push_back(arr_rd);
    // whole run fits inside one average refresh interval
    if (cycles == 700) begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic do_reset(input logic ck);
    @(posedge clk_sys);
    rst <= 1'b1;
    ctl.send(4'hf, ck, 2'h0, 12'h000);
    repeat (9) @(posedge clk_sys);
    rst <= 1'b0;
    step(3);
    `CHK("dual_rank", ck, dual_rank)
    `CHK("addr_term_half", ~ck, addr_term_half)
    `CHK("cmd_term", 1'b1, cmd_term_enable)
    `CHK("dll_enable", 1'b1, dll_enable)
    `CHK("bank_open", 4'h0, bank_open)
  endtask

  task automatic t_read();
    rq.delete();
    ctl.send(4'h3, 1'b1, 2'h2, 12'h5a5);
    ctl.gap(4);
    ctl.send(4'hd, 1'b1, 2'h2, 12'h23c);
    ctl.send(4'h5, 1'b1, 2'h3, 12'h23c);
    ctl.send(4'h5, 1'b1, 2'h2, 12'h23c);
    step(3);
    `CHK("bank_open", 4'h4, bank_open)
    `CHK("reads", 1, rq.size())
    `CHK("rd", {2'h2, 12'h5a5, 9'h13c, 5'h04}, {rq[0].bank, rq[0].row, rq[0].col, rq[0].len})
  endtask

  task automatic t_write();
    wq.delete();
    ctl.write(2'h2, 12'h205, 32'hc0de_1000);
    step(2);
    `CHK("beats", 4, wq.size())
    for (int i = 0; i < 4; i++) begin
      `CHK("beat", {2'h2, 12'h5a5, 9'h105 + 9'(i), 32'hc0de_1000 + 32'(i), ~(4'(i * 5))}, {wq[i].bank, wq[i].row, wq[i].col, wq[i].data, wq[i].byte_en})
    end
  endtask

  task automatic t_pre();
    ctl.send(4'h3, 1'b1, 2'h0, 12'h0f0);
    ctl.gap(4);
    step(0);
    `CHK("bank_open", 4'h5, bank_open)
    ctl.send(4'h2, 1'b1, 2'h2, 12'h000);
    step(5);
    `CHK("bank_open", 4'h1, bank_open)
    ctl.send(4'h2, 1'b1, 2'h2, 12'h100);
    step(5);
    `CHK("bank_open", 4'h0, bank_open)
  endtask

  task automatic t_autopre();
    ctl.send(4'h3, 1'b1, 2'h1, 12'h011);
    ctl.send(4'h3, 1'b1, 2'h3, 12'h033);
    ctl.gap(4);
    ctl.send(4'h5, 1'b1, 2'h1, 12'h104);
    ctl.send(4'h5, 1'b1, 2'h3, 12'h004);
    step(12);
    `CHK("bank_open", 4'h8, bank_open)
    ctl.send(4'h3, 1'b1, 2'h1, 12'h022);
    ctl.gap(4);
    ctl.send(4'h5, 1'b1, 2'h1, 12'h008);
    ctl.write(2'h3, 12'h100, 32'h5555_0000);
    step(14);
    `CHK("bank_open", 4'h2, bank_open)
  endtask

  task automatic t_mode();
    ctl.send(4'h2, 1'b1, 2'h0, 12'h100);
    ctl.gap(4);
    ctl.send(4'h0, 1'b1, 2'h0, 12'h123);
    ctl.send(4'h0, 1'b1, 2'h1, 12'h456);
    ctl.send(4'h0, 1'b1, 2'h2, 12'hfff);
    ctl.send(4'h0, 1'b1, 2'h3, 12'hfff);
    ctl.send(4'h8, 1'b1, 2'h0, 12'h777);
    step(2);
    `CHK("mode_reg", 12'h123, mode_reg)
    `CHK("ext_mode_reg", 12'h456, ext_mode_reg)
  endtask

  task automatic t_refresh();
    r0 = refresh_row;
    for (int i = 0; i < 2; i++) begin
      ctl.send(4'h1, 1'b1, 2'h3, 12'hfff - 12'(i));
      step(0);
      `CHK("refresh_pulse", 1'b1, refresh_pulse)
      `CHK("refresh_row", r0 + 12'(i + 1), refresh_row)
      step(1);
      `CHK("refresh_pulse", 1'b0, refresh_pulse)
    end
    ctl.send(4'h9, 1'b1, 2'h0, 12'h000);
    step(2);
    `CHK("refresh_row", r0 + 12'h002, refresh_row)
  endtask

  task automatic t_snoop(input logic [3:0] lat, input logic [4:0] beats);
    int lo;
    int hi;
    @(posedge clk_sys);
    read_latency   <= lat;
    burst_length   <= beats;
    dual_load_term <= 1'b1;
    // Off in effect at the edge latency-1 clocks after the snooped read
    lo = int'(lat) - 2;
    hi = lo + int'(beats) / 2 + 1;
    ctl.send(4'hd, 1'b1, 2'h0, 12'h000);
    for (int k = 0; k < 12; k++) begin
      step(int'(k != 0));
      `CHK("dq_term", 1'(!(k >= lo && k <= hi)), dq_term_enable)
    end
    @(posedge clk_sys);
    dual_load_term <= 1'b0;
  endtask

  task automatic t_self();
    ctl.send(4'h1, 1'b0, 2'h0, 12'h000);
    step(0);
    `CHK("self_refresh", 1'b1, self_refresh)
    `CHK("dll_enable", 1'b0, dll_enable)
    `CHK("dq_term", 1'b0, dq_term_enable)
    `CHK("refresh_pulse", 1'b0, refresh_pulse)
    ctl.send(4'h3, 1'b0, 2'h1, 12'h0aa);
    // exit with no-ops only, no read follows
    ctl.send(4'h7, 1'b1, 2'h0, 12'h000);
    step(0);
    `CHK("self_refresh", 1'b0, self_refresh)
    `CHK("dll", 2'h3, {dll_enable, dll_reset})
    step(1);
    `CHK("dll_reset", 1'b0, dll_reset)
    step(1);
    `CHK("dq_term", 1'b1, dq_term_enable)
    step(6);
    `CHK("bank_open", 4'h0, bank_open)
  endtask

  initial begin
    do_reset(1'b1);
    t_read();
    t_write();
    t_pre();
    t_autopre();
    t_mode();
    t_refresh();
    t_snoop(4'h5, 5'h04);
    t_snoop(4'h6, 5'h08);
    t_self();
    do_reset(1'b0);
    complete_run();
  end
endmodule
